// file: verilog/spcr_defines.vh
`ifndef SPCR_DEFINES_VH
`define SPCR_DEFINES_VH

// Register addresses as carried in the 13-bit address field
`define SPCR_ADDR_W       13
`define SPCR_ADDR_CFG     13'h0000
`define SPCR_ADDR_PART    13'h0003
`define SPCR_ADDR_RBSEL   13'h0004
`define SPCR_ADDR_PDS     13'h0230
`define SPCR_ADDR_RSV     13'h0231
`define SPCR_ADDR_UPD     13'h0232
`define SPCR_ADDR_STEP    13'h0001

// Serial port configuration fields
`define SPCR_CFG_SEP      0
`define SPCR_CFG_LSB      1
`define SPCR_CFG_SRST     2
`define SPCR_CFG_LONG     3
`define SPCR_CFG_RESET    8'h18
`define SPCR_CFG_SRST_MSK 8'h04

// Reset values of the other registers
`define SPCR_RBSEL_RESET  1'h0
`define SPCR_RSV_RESET    8'h00
`define SPCR_UPD_RESET    1'h0
`define SPCR_ZERO_BYTE    8'h00
`define SPCR_UPD_BIT      0
`define SPCR_RBSEL_BIT    0

// Instruction word layout
`define SPCR_INS_RW       15
`define SPCR_INS_LEN_HI   14
`define SPCR_INS_LEN_LO   13
`define SPCR_INS_ADDR_HI  12
`define SPCR_LEN_STREAM   2'h3
`define SPCR_LEN_NONE     2'h0

// Bit counts, zero based
`define SPCR_CNT_ZERO     4'h0
`define SPCR_CNT_ONE      4'h1
`define SPCR_INSTR_LAST   4'hf
`define SPCR_BYTE_LAST    4'h7

`endif

// file: verilog/spcr_bank.v
`timescale 1ns/1ns
`include "spcr_defines.vh"

module spcr_bank #(
	parameter [7:0] VARIANT_ID = 8'h5a, // Variant code, value arbitrary
	parameter [7:0] PDS_RESET  = 8'h00  // Power-down/sync default
) (
	input  wire                    mclk,       // System clock
	input  wire                    rst,        // Synchronous reset, active high
	input  wire                    wr_en,      // One-cycle write strobe
	input  wire [`SPCR_ADDR_W-1:0] wr_addr,    // Write address
	input  wire [7:0]              wr_data,    // Write data
	input  wire [`SPCR_ADDR_W-1:0] rd_addr,    // Read address
	output reg  [7:0]              rd_data,    // Read data, combinational
	output wire [7:0]              cfg,        // Port configuration
	output wire [7:0]              pds_active  // Active power-down/sync value
);

	reg [7:0] cfg_ff;
	reg       rbsel_ff;
	reg [7:0] pds_buf_ff;
	reg [7:0] pds_act_ff;
	reg [7:0] rsv_buf_ff;
	reg [7:0] rsv_act_ff;
	reg       upd_ff;

	wire srst = cfg_ff[`SPCR_CFG_SRST];
	wire wr_cfg = wr_en && (wr_addr == `SPCR_ADDR_CFG);
	wire wr_rbsel = wr_en && (wr_addr == `SPCR_ADDR_RBSEL);
	wire wr_pds = wr_en && (wr_addr == `SPCR_ADDR_PDS);
	wire wr_rsv = wr_en && (wr_addr == `SPCR_ADDR_RSV);
	wire wr_upd = wr_en && (wr_addr == `SPCR_ADDR_UPD);

	assign cfg = cfg_ff;
	assign pds_active = pds_act_ff;

	// Config register; soft reset pins the other fields at default
	always @(posedge mclk) begin
		if (rst) begin
			cfg_ff <= `SPCR_CFG_RESET;
		end else if (wr_cfg) begin
			cfg_ff <= wr_data;
		end else if (srst) begin
			cfg_ff <= `SPCR_CFG_RESET | `SPCR_CFG_SRST_MSK;
		end
	end

	// Buffer and active banks; soft reset beats a pending commit
	always @(posedge mclk) begin
		if (rst || srst) begin
			rbsel_ff   <= `SPCR_RBSEL_RESET;
			pds_buf_ff <= PDS_RESET;
			pds_act_ff <= PDS_RESET;
			rsv_buf_ff <= `SPCR_RSV_RESET;
			rsv_act_ff <= `SPCR_RSV_RESET;
			upd_ff     <= `SPCR_UPD_RESET;
		end else begin
			if (wr_rbsel) begin
				rbsel_ff <= wr_data[`SPCR_RBSEL_BIT];
			end
			if (wr_pds) begin
				pds_buf_ff <= wr_data;
			end
			if (wr_rsv) begin
				rsv_buf_ff <= wr_data;
			end
			// Bit stands one cycle, then clears itself
			upd_ff <= wr_upd && wr_data[`SPCR_UPD_BIT];
			if (upd_ff) begin
				pds_act_ff <= pds_buf_ff;
				rsv_act_ff <= rsv_buf_ff;
			end
		end
	end

	// Readback mux; identifier is a constant so writes cannot touch it
	always @* begin
		case (rd_addr)
			`SPCR_ADDR_CFG:   rd_data = cfg_ff;
			`SPCR_ADDR_PART:  rd_data = VARIANT_ID;
			`SPCR_ADDR_RBSEL: rd_data = {7'h00, rbsel_ff};
			`SPCR_ADDR_PDS:   rd_data = rbsel_ff ? pds_act_ff : pds_buf_ff;
			`SPCR_ADDR_RSV:   rd_data = rbsel_ff ? rsv_act_ff : rsv_buf_ff;
			`SPCR_ADDR_UPD:   rd_data = {7'h00, upd_ff};
			default:          rd_data = `SPCR_ZERO_BYTE;
		endcase
	end

endmodule // spcr_bank

// file: verilog/spcr_port.v
// Overview of operation
// - Instruction length bit: 0 short, 1 long default; only 16-bit used.
// - While soft reset is one, internal registers hold their defaults.
// - Soft reset bit stays set until the host writes it to zero.
// - Bit order zero: MSB first, address decrements per further byte.
// - Bit order one: LSB first, address increments per further byte.
// - Output select zero: data pin shared, separate output pin released.
// - Output select one: reads on separate output pin, writes on data pin.
// - Eight-bit read-only variant identifier; writes have no effect.
// - Readback select zero returns buffer bank, one returns active bank.
// - Writing one to update-all commits registers; bit clears itself.
// - Update-all and reserved register below it reset to zero.
`timescale 1ns/1ns
`include "spcr_defines.vh"

module spcr_port #(
	parameter [7:0] VARIANT_ID = 8'h5a, // Variant code, value arbitrary
	parameter [7:0] PDS_RESET  = 8'h00  // Power-down/sync default
) (
	input  wire       mclk,            // System clock, 20 MHz
	input  wire       rst,             // Synchronous reset, active high
	input  wire       sclk,            // Serial clock, sampled on mclk
	input  wire       cs_n,            // Chip select, active low
	input  wire       sdio_in,         // Data pin, input side
	output reg        sdio_out,        // Data pin, output side
	output reg        sdio_oe_n,       // Data pin drive enable, active low
	output reg        serial_out_pin,  // Separate serial output
	output reg        serial_out_oe_n, // Separate output enable, active low
	output wire [7:0] pds_active       // Active power-down/sync register
);

	// Transfer phases
	localparam [2:0] ST_INSTR = 3'h0;
	localparam [2:0] ST_WDATA = 3'h1;
	localparam [2:0] ST_RLOAD = 3'h2;
	localparam [2:0] ST_RDATA = 3'h3;
	localparam [2:0] ST_HOLD  = 3'h4;

	reg  [2:0]              st_ff;
	reg                     sclk_ff;
	reg  [3:0]              cnt_ff;
	reg  [15:0]             ins_ff;
	reg  [7:0]              byte_ff;
	reg  [`SPCR_ADDR_W-1:0] addr_ff;
	reg  [1:0]              rem_ff;
	reg                     strm_ff;
	reg                     wr_en_ff;
	reg  [`SPCR_ADDR_W-1:0] wr_addr_ff;
	reg  [7:0]              wr_data_ff;
	wire [7:0]              cfg;
	wire [7:0]              rd_data;
	wire [15:0]             nxt_ins;
	wire [7:0]              nxt_byte;
	wire [`SPCR_ADDR_W-1:0] nxt_addr;
	wire                    lsb_first;
	wire                    sep_out;
	wire                    sclk_rise;
	wire                    sclk_fall;
	wire                    last_byte;
	wire                    out_bit;

	spcr_bank #(
		.VARIANT_ID (VARIANT_ID),
		.PDS_RESET  (PDS_RESET)
	) u_bank (
		.mclk       (mclk),
		.rst        (rst),
		.wr_en      (wr_en_ff),
		.wr_addr    (wr_addr_ff),
		.wr_data    (wr_data_ff),
		.rd_addr    (addr_ff),
		.rd_data    (rd_data),
		.cfg        (cfg),
		.pds_active (pds_active)
	);

	// The long-instruction bit is stored for readback only; the port
	// always decodes a 16-bit instruction, so a host clearing it breaks
	// framing rather than switching to the short form.
	assign lsb_first = cfg[`SPCR_CFG_LSB];
	assign sep_out   = cfg[`SPCR_CFG_SEP];

	// Edges of the serial clock seen at mclk; sclk must stay in each
	// level for at least two mclk cycles
	assign sclk_rise = sclk && !sclk_ff;
	assign sclk_fall = !sclk && sclk_ff;

	// Shift direction follows the bit-order control
	assign nxt_ins  = lsb_first ? {sdio_in, ins_ff[15:1]} : {ins_ff[14:0], sdio_in};
	assign nxt_byte = lsb_first ? {sdio_in, byte_ff[7:1]} : {byte_ff[6:0], sdio_in};
	assign out_bit  = lsb_first ? byte_ff[0] : byte_ff[7];

	// Address steps up in LSB-first mode and down in MSB-first mode
	assign nxt_addr = lsb_first ? addr_ff + `SPCR_ADDR_STEP : addr_ff - `SPCR_ADDR_STEP;

	// Fixed-length transfers end when the byte count runs out
	assign last_byte = !strm_ff && (rem_ff == `SPCR_LEN_NONE);

	// Serial clock history for edge detection
	always @(posedge mclk) begin
		if (rst) begin
			sclk_ff <= 1'b0;
		end else begin
			sclk_ff <= sclk;
		end
	end

	// Transfer sequencer; chip select high aborts anything in flight
	always @(posedge mclk) begin
		if (rst) begin
			st_ff      <= ST_INSTR;
			cnt_ff     <= `SPCR_CNT_ZERO;
			ins_ff     <= 16'h0000;
			byte_ff    <= 8'h00;
			addr_ff    <= `SPCR_ADDR_CFG;
			rem_ff     <= `SPCR_LEN_NONE;
			strm_ff    <= 1'b0;
			wr_en_ff   <= 1'b0;
			wr_addr_ff <= `SPCR_ADDR_CFG;
			wr_data_ff <= 8'h00;
		end else begin
			wr_en_ff <= 1'b0;
			if (cs_n) begin
				st_ff  <= ST_INSTR;
				cnt_ff <= `SPCR_CNT_ZERO;
			end else begin
				case (st_ff)
					ST_INSTR: begin
						if (sclk_rise) begin
							ins_ff <= nxt_ins;
							cnt_ff <= cnt_ff + `SPCR_CNT_ONE;
							if (cnt_ff == `SPCR_INSTR_LAST) begin
								// Always the 16-bit form
								addr_ff <= nxt_ins[`SPCR_INS_ADDR_HI:0];
								rem_ff  <= nxt_ins[`SPCR_INS_LEN_HI:`SPCR_INS_LEN_LO];
								strm_ff <= (nxt_ins[`SPCR_INS_LEN_HI:`SPCR_INS_LEN_LO]
									== `SPCR_LEN_STREAM);
								cnt_ff  <= `SPCR_CNT_ZERO;
								st_ff   <= nxt_ins[`SPCR_INS_RW] ? ST_RLOAD : ST_WDATA;
							end
						end
					end
					ST_WDATA: begin
						if (sclk_rise) begin
							byte_ff <= nxt_byte;
							cnt_ff  <= cnt_ff + `SPCR_CNT_ONE;
							if (cnt_ff == `SPCR_BYTE_LAST) begin
								// Write data only ever comes on the data pin
								wr_en_ff   <= 1'b1;
								wr_addr_ff <= addr_ff;
								wr_data_ff <= nxt_byte;
								addr_ff    <= nxt_addr;
								cnt_ff     <= `SPCR_CNT_ZERO;
								rem_ff     <= rem_ff - 2'h1;
								if (last_byte) begin
									st_ff <= ST_HOLD;
								end
							end
						end
					end
					ST_RLOAD: begin
						// One mclk to fetch the addressed byte
						byte_ff <= rd_data;
						st_ff   <= ST_RDATA;
					end
					ST_RDATA: begin
						if (sclk_fall) begin
							byte_ff <= lsb_first ? {1'b0, byte_ff[7:1]} : {byte_ff[6:0], 1'b0};
							cnt_ff  <= cnt_ff + `SPCR_CNT_ONE;
							if (cnt_ff == `SPCR_BYTE_LAST) begin
								addr_ff <= nxt_addr;
								cnt_ff  <= `SPCR_CNT_ZERO;
								rem_ff  <= rem_ff - 2'h1;
								st_ff   <= last_byte ? ST_HOLD : ST_RLOAD;
							end
						end
					end
					ST_HOLD: begin
						// Extra clocks are ignored until chip select rises
						st_ff <= ST_HOLD;
					end
					default: begin
						st_ff <= ST_INSTR;
					end
				endcase
			end
		end
	end

	// Pin drivers; read bits change on the falling serial clock edge
	always @(posedge mclk) begin
		if (rst) begin
			sdio_out        <= 1'b0;
			sdio_oe_n       <= 1'b1;
			serial_out_pin  <= 1'b0;
			serial_out_oe_n <= 1'b1;
		end else if (cs_n) begin
			sdio_oe_n       <= 1'b1;
			serial_out_oe_n <= 1'b1;
		end else if (st_ff == ST_RDATA && sclk_fall) begin
			sdio_out        <= out_bit;
			serial_out_pin  <= out_bit;
			// Shared pin unless separate output is selected
			sdio_oe_n       <= sep_out;
			serial_out_oe_n <= !sep_out;
		end
	end

endmodule // spcr_port

// file: test/spcr_port_sva.sv
`timescale 1ns/1ns
// Port-level checks of the serial configuration port
module spcr_port_sva #(
	parameter [7:0] PDS_RESET = 8'h00 // Power-down/sync default
) (
	input wire       mclk,            // Clock
	input wire       rst,             // Reset
	input wire       sclk,            // Serial clock
	input wire       cs_n,            // Select
	input wire       sdio_in,         // Data pin in
	input wire       sdio_out,        // Data pin out
	input wire       sdio_oe_n,       // Data pin enable
	input wire       serial_out_pin,  // Separate out
	input wire       serial_out_oe_n, // Separate enable
	input wire [7:0] pds_active       // Active register
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_reset_quiet: assert property ($fell(rst) |-> sdio_oe_n && serial_out_oe_n
		&& !sdio_out && pds_active == PDS_RESET) else $error("outputs not idle after reset");
	a_one_driver: assert property (sdio_oe_n || serial_out_oe_n)
		else $error("both output pins driven");
	a_pin_copy: assert property (serial_out_pin == sdio_out)
		else $error("output pins disagree");
	a_release_idle: assert property (cs_n [*2] |=> sdio_oe_n && serial_out_oe_n)
		else $error("pin driven outside frame");
	a_drive_in_frame: assert property (($fell(sdio_oe_n) || $fell(serial_out_oe_n))
		|-> !cs_n && !$past(cs_n)) else $error("drive began without select");
	a_hold_frame: assert property (!sdio_oe_n && !cs_n |=> !sdio_oe_n)
		else $error("data pin released mid frame");
	a_bit_on_fall: assert property (!sdio_oe_n && !$past(sdio_oe_n) && $changed(sdio_out)
		|-> !sclk && !$past(sclk)) else $error("read bit moved off a falling edge");
	a_sep_on_fall: assert property (!serial_out_oe_n && !$past(serial_out_oe_n)
		&& $changed(serial_out_pin) |-> !sclk && !$past(sclk))
		else $error("separate bit moved off a falling edge");
	a_pds_quiet: assert property (cs_n [*6] |=> $stable(pds_active))
		else $error("active register moved while idle");
	c_read_shared: cover property (!sdio_oe_n);
	c_read_sep: cover property (!serial_out_oe_n);
	c_commit: cover property ($changed(pds_active));
endmodule // spcr_port_sva

bind spcr_port spcr_port_sva #(.PDS_RESET(PDS_RESET)) i_spcr_port_sva (.mclk(mclk), .rst(rst),
	.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
	.serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n), .pds_active(pds_active));

// file: test/spcr_host.sv
`timescale 1ns/1ns
// Host controller on the far side of the serial port
module spcr_host (
	input  wire mclk,          // Clock
	output reg  sclk,          // Serial clock
	output reg  cs_n,          // Select, active low
	output wire sdio_in,       // Data pin level
	input  wire sdio_out,      // Device data out
	input  wire sdio_oe_n,     // Device data enable
	input  wire serial_out_pin // Device separate out
);
	reg hbit = 1'b0;
	reg hdrv = 1'b0;
	// Released pin shows the inverse of the last bit so a stale value never reads right
	assign sdio_in = !sdio_oe_n ? sdio_out : (hdrv ? hbit : ~hbit);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
	end
	// One frame; clock halves of 3+ cycles keep above the 2-cycle minimum
	task xfer(input rd, input [12:0] a, input integer nb, input [15:0] wd, input lsb,
		input sep, output [15:0] rv);
		reg [15:0] ins;
		integer i;
		integer x;
		begin
			ins = {rd, ((nb == 2) ? 2'h1 : 2'h0), a};
			rv = 16'h0000;
			@(posedge mclk);
			cs_n <= 1'b0;
			hdrv <= 1'b1;
			repeat (2) @(posedge mclk);
			for (i = 0; i < 16 + 8 * nb; i = i + 1) begin
				x = (i < 16) ? (lsb ? i : 15 - i) : 15 - 8 * ((i - 16) / 8) - (lsb ? 7 - i % 8 : i % 8);
				sclk <= 1'b0;
				hbit <= (i < 16) ? ins[x] : wd[x];
				hdrv <= !(rd && i >= 16);
				repeat (4) @(posedge mclk);
				#1 if (i >= 16) rv[x] = sep ? serial_out_pin : sdio_out;
				@(posedge mclk) sclk <= 1'b1;
				repeat (3) @(posedge mclk);
			end
			// Extra wait lets the last byte land before select goes away
			repeat (2) @(posedge mclk);
			cs_n <= 1'b1;
			sclk <= 1'b0;
			hdrv <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask
endmodule // spcr_host

// file: test/spcr_port_tb.sv
`timescale 1ns/1ns
module spcr_port_tb;
	reg        mclk = 1'b0;
	reg        rst = 1'b1;
	reg        lsb = 1'b0;
	reg        sep = 1'b0;
	wire       sclk;
	wire       cs_n;
	wire       sdio_in;
	wire       sdio_out;
	wire       sdio_oe_n;
	wire       so_pin;
	wire       so_oe_n;
	wire [7:0] pds;
	integer    n_errors = 0;
	integer    checks_done = 0;
	// 20 MHz clock
	always #25 mclk = ~mclk;
	spcr_port i_spcr_port (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.serial_out_pin(so_pin), .serial_out_oe_n(so_oe_n), .pds_active(pds));
	spcr_host i_spcr_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .serial_out_pin(so_pin));
	task finish_test;
		begin
			if (n_errors == 0 && checks_done > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Register access through the host model; data byte 0 sits in bits 15:8
	task wr(input [12:0] a, input [15:0] d, input integer nb);
		reg [15:0] r;
		i_spcr_host.xfer(1'b0, a, nb, d, lsb, sep, r);
	endtask
	task rd(input [12:0] a, input [7:0] e);
		reg [15:0] r;
		begin
			i_spcr_host.xfer(1'b1, a, 1, 16'h0000, lsb, sep, r);
			chk(r[15:8], e);
		end
	endtask
	task t_defaults;
		begin
			rd(13'h0000, 8'h18);
			rd(13'h0003, 8'h5a);
			rd(13'h0231, 8'h00);
			rd(13'h0232, 8'h00);
		end
	endtask
	// Buffer versus active bank, commit and its self-clear
	task t_commit;
		begin
			wr(13'h0230, 16'ha500, 1);
			chk(pds, 8'h00);
			rd(13'h0230, 8'ha5);
			wr(13'h0004, 16'h0100, 1);
			rd(13'h0004, 8'h01);
			rd(13'h0230, 8'h00);
			wr(13'h0232, 16'h0100, 1);
			chk(pds, 8'ha5);
			rd(13'h0232, 8'h00);
			wr(13'h0004, 16'h0000, 1);
			wr(13'h0003, 16'hff00, 1);
			rd(13'h0003, 8'h5a);
		end
	endtask
	// Mirrored config words keep the meaning whichever order the port is in
	task t_order;
		begin
			wr(13'h0000, 16'h5a00, 1);
			lsb = 1'b1;
			rd(13'h0000, 8'h5a);
			wr(13'h0230, 16'h1234, 2);
			rd(13'h0230, 8'h12);
			rd(13'h0231, 8'h34);
			wr(13'h0000, 16'h1800, 1);
			lsb = 1'b0;
			wr(13'h0231, 16'h5678, 2);
			rd(13'h0231, 8'h56);
			rd(13'h0230, 8'h78);
		end
	endtask
	task t_sep;
		begin
			wr(13'h0000, 16'h9900, 1);
			sep = 1'b1;
			rd(13'h0003, 8'h5a);
			wr(13'h0000, 16'h1800, 1);
			sep = 1'b0;
			rd(13'h0000, 8'h18);
		end
	endtask
	task t_soft;
		begin
			wr(13'h0000, 16'h3c00, 1);
			chk(pds, 8'h00);
			rd(13'h0000, 8'h1c);
			rd(13'h0230, 8'h00);
			wr(13'h0000, 16'h1800, 1);
			rd(13'h0000, 8'h18);
		end
	endtask
	// Mid-run reset returns both banks to their defaults
	task t_reset;
		begin
			wr(13'h0231, 16'h3344, 2);
			wr(13'h0232, 16'h0100, 1);
			chk(pds, 8'h44);
			rst <= 1'b1;
			repeat (2) @(posedge mclk);
			rst <= 1'b0;
			chk(pds, 8'h00);
			rd(13'h0231, 8'h00);
			rd(13'h0000, 8'h18);
		end
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_defaults;
		t_commit;
		t_order;
		t_sep;
		t_soft;
		t_reset;
		finish_test;
	end
	// Whole run needs about 7.4k cycles; cut off a hang at 40k
	initial begin
		#2000000;
		n_errors = n_errors + 1;
		finish_test;
	end
endmodule // spcr_port_tb
